// ---- dv/dsb_motor_model.sv ----
/*
 * dsb_motor_model: behavioural motor and power stage seen by the sequencer.
 * Assumes OUT_EN and RAMP_DOWN come from the sequencer on SYS_CLK and that
 * the bench may hold the feedback speed up to mimic a load that keeps going.
 */
`timescale 1ns/1ps
module dsb_motor_model
   import dsb_pkg::*;
(
   // clock
   input  wire logic              SYS_CLK,
   // sequencer side
   input  wire logic              OUT_EN,
   input  wire logic              RAMP_DOWN,
   // load behaviour chosen by the bench
   input  wire logic              HOLD_FB,
   // frequencies back to the sequencer
   output logic      [FREQ_W-1:0] RAMP_FREQ,
   output logic      [FREQ_W-1:0] FB_FREQ
);
   localparam logic [FREQ_W-1:0] TOP  = 16'h1388;
   localparam logic [FREQ_W-1:0] STEP = 16'h0064;
   logic [FREQ_W-1:0] ramp_ff = 16'h0000;
   logic [FREQ_W-1:0] fb_ff   = 16'h0000;

   // -------------------------------------------------------------------
   // ramp and shaft speed
   // -------------------------------------------------------------------
   // blocked output drops the ramp at once; the shaft only coasts down
   always @(posedge SYS_CLK) begin
      if (!OUT_EN) begin
         ramp_ff <= 16'h0000;
      end else if (RAMP_DOWN) begin
         ramp_ff <= (ramp_ff > STEP) ? ramp_ff - STEP : 16'h0000;
      end else if (ramp_ff < TOP) begin
         ramp_ff <= ramp_ff + STEP;
      end
      if (HOLD_FB) begin
         fb_ff <= fb_ff;
      end else if (OUT_EN) begin
         fb_ff <= ramp_ff;
      end else begin
         fb_ff <= (fb_ff > STEP) ? fb_ff - STEP : 16'h0000;
      end
   end
   assign RAMP_FREQ = ramp_ff;
   assign FB_FREQ   = fb_ff;
endmodule : dsb_motor_model

// ---- dv/testbench.sv ----
/*
 * testbench: scenario tasks for the stop, brake and restart sequencer.
 * Assumes the sequencer built with a 4-cycle tick and the motor model.
 */
`timescale 1ns/1ps
module testbench
   import dsb_pkg::*;
;
   logic sys_clk, rst, run_term, term_src, run_req, stop_req, start_ok;
   logic run_mem_in, stop_mode, det_src, pl_en, pot_sel, hold_fb;
   logic [FREQ_W-1:0] brk_f, thr, ramp_freq, fb_freq, max_f;
   logic [TIME_W-1:0] demag, dc_t, det_t, spd_dly, sc_hold, rw_t, st_dly;
   logic [PCT_W-1:0]  dc_cur, sc_cur, brake_cur;
   logic out_en, ramp_down, short_brk, dc_brk, standby, run_mem_out, protect;
   int num_errors = 0;
   int total_checks = 0;

   dsb_seq #(.TICK_CYC(4)) DUT (.SYS_CLK(sys_clk), .RST(rst),
      .RUN_TERM(run_term), .TERM_SRC(term_src), .RUN_REQ(run_req),
      .STOP_REQ(stop_req), .START_OK(start_ok), .RUN_MEM_IN(run_mem_in),
      .STOP_MODE_SEL(stop_mode), .MAX_OUTPUT_FREQ(max_f),
      .STOP_BRAKE_START_FREQ(brk_f), .DEMAG_WAIT_TIME(demag),
      .STOP_DC_BRAKE_CURRENT(dc_cur), .STOP_DC_BRAKE_TIME(dc_t),
      .STOP_SPEED_THRESHOLD(thr), .STOP_DETECT_SOURCE(det_src),
      .STOP_DETECT_TIME(det_t), .STOP_SPEED_DELAY(spd_dly),
      .SHORT_BRAKE_CURRENT(sc_cur), .SHORT_BRAKE_STOP_HOLD(sc_hold),
      .POWER_LOSS_RESTART_EN(pl_en), .RESTART_WAIT_TIME(rw_t),
      .RUN_START_DELAY(st_dly), .POWERON_TERMINAL_RUN_SEL(pot_sel),
      .RAMP_FREQ(ramp_freq), .FB_FREQ(fb_freq), .OUT_EN(out_en),
      .RAMP_DOWN(ramp_down), .SHORT_BRAKE(short_brk), .DC_BRAKE(dc_brk),
      .BRAKE_CUR(brake_cur), .STANDBY(standby),
      .RUN_MEM_OUT(run_mem_out), .PROTECT(protect));
   dsb_motor_model motor (.SYS_CLK(sys_clk), .OUT_EN(out_en),
      .RAMP_DOWN(ramp_down), .HOLD_FB(hold_fb), .RAMP_FREQ(ramp_freq),
      .FB_FREQ(fb_freq));

   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   // -------------------------------------------------------------------
   // helpers
   // -------------------------------------------------------------------
   task automatic summarize;
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : summarize

   task automatic bad(input string what);
      num_errors++;
      $display("wrong value at %0t: %s", $time, what);
   endtask : bad

   task automatic chk_bit(input logic got, input logic exp, input string w);
      total_checks++;
      if (got !== exp) bad(w);
   endtask : chk_bit

   task automatic chk_cnt(input int got, input int lo, input int hi,
                          input string w);
      total_checks++;
      if (got < lo || got > hi) bad(w);
   endtask : chk_cnt

   task automatic chk_cur(input logic [PCT_W-1:0] got,
                          input logic [PCT_W-1:0] exp, input string w);
      total_checks++;
      if (got !== exp) bad(w);
   endtask : chk_cur

   task automatic cyc(input int k);
      repeat (k) @(posedge sys_clk);
      #1;
   endtask : cyc

   function automatic logic pick(input int k);
      case (k)
         0: return out_en;
         1: return standby;
         2: return short_brk;
         3: return dc_brk;
         4: return ramp_down;
         6: return ramp_freq < thr;
         7: return ramp_freq < brk_f;
         8: return short_brk | dc_brk;
         default: return 1'bx;
      endcase
   endfunction : pick

   // a bound that runs out ends the run through the closing report
   task automatic wait_lvl(input int k, input logic v, input int lim,
                           output int n);
      n = 0;
      while (pick(k) !== v) begin
         cyc(1);
         n++;
         if (n > lim) begin
            bad("wait ran out");
            summarize();
         end
      end
   endtask : wait_lvl

   task automatic watch(input int k, input int len, output logic seen);
      seen = 1'b0;
      repeat (len) begin
         cyc(1);
         if (pick(k) !== 1'b0) seen = 1'b1;
      end
   endtask : watch

   task automatic do_reset;
      rst = 1'b1;
      cyc(20);
      rst = 1'b0;
   endtask : do_reset

   task automatic go_run;
      int n;
      cyc(3);
      run_req = 1'b1;
      wait_lvl(0, 1'b1, 60, n);
      cyc(60);
      run_req = 1'b0;
   endtask : go_run

   // -------------------------------------------------------------------
   // scenarios
   // -------------------------------------------------------------------
   task automatic sc_start;
      int n;
      st_dly = 16'h0001;
      run_req = 1'b1;
      wait_lvl(1, 1'b1, 5, n);
      chk_bit(out_en, 1'b0, "output on in start delay");
      wait_lvl(0, 1'b1, 60, n);
      chk_cnt(n, 39, 46, "start delay length");
      chk_bit(standby, 1'b0, "standby after delay");
      chk_bit(run_mem_out, 1'b1, "running not remembered");
      st_dly = 16'h0000;
      cyc(60);
   endtask : sc_start

   task automatic sc_coast;
      int n;
      stop_mode = STOP_MODE_COAST;
      run_req = 1'b0;
      wait_lvl(0, 1'b0, 4, n);
      chk_bit(ramp_down, 1'b0, "ramp in coast stop");
      chk_bit(run_mem_out, 1'b0, "stopped still remembered");
      stop_mode = STOP_MODE_DECEL;
   endtask : sc_coast

   task automatic sc_brake;
      int n;
      brk_f = 16'h03E8;
      demag = 16'h0002;
      sc_hold = 16'h0001;
      dc_t = 16'h0001;
      sc_cur = 11'h5DC;
      dc_cur = 11'h3E8;
      go_run();
      wait_lvl(4, 1'b1, 4, n);
      wait_lvl(7, 1'b1, 80, n);
      wait_lvl(0, 1'b0, 3, n);
      sc_cur = 11'h001;
      dc_cur = 11'h064;
      wait_lvl(2, 1'b1, 20, n);
      chk_cnt(n, 7, 12, "demag wait");
      chk_cur(brake_cur, 11'h5DC, "short current");
      wait_lvl(3, 1'b1, 50, n);
      chk_cnt(n, 39, 46, "short hold");
      chk_bit(short_brk, 1'b0, "short with dc");
      chk_cur(brake_cur, 11'h3E8, "dc current");
      wait_lvl(3, 1'b0, 50, n);
      chk_cnt(n, 39, 46, "dc time");
      chk_bit(out_en, 1'b0, "output after dc");
      chk_cur(brake_cur, 11'h000, "current after dc");
   endtask : sc_brake

   task automatic sc_skip;
      int n;
      logic seen;
      // start frequency above the maximum must be cut to the maximum
      brk_f = 16'h1388;
      max_f = 16'h03E8;
      demag = 16'h0000;
      sc_hold = 16'h0000;
      dc_t = 16'h0000;
      go_run();
      wait_lvl(0, 1'b0, 80, n);
      chk_cnt(n, 40, 46, "brake frequency not clamped");
      watch(8, 30, seen);
      chk_bit(seen, 1'b0, "braking with zero times");
      chk_bit(out_en, 1'b0, "output after skipped brake");
   endtask : sc_skip

   task automatic sc_setsrc;
      int n;
      logic seen;
      brk_f = 16'h0000;
      sc_hold = 16'h0001;
      dc_t = 16'h0001;
      det_src = DET_SET_SPEED;
      spd_dly = 16'h0001;
      go_run();
      wait_lvl(6, 1'b1, 80, n);
      wait_lvl(0, 1'b0, 60, n);
      chk_cnt(n, 39, 46, "stop speed delay");
      watch(8, 20, seen);
      chk_bit(seen, 1'b0, "braking with zero brake freq");
   endtask : sc_setsrc

   task automatic sc_fb(input logic hold, input int lo, input int hi);
      int n;
      det_src = DET_FB_SPEED;
      spd_dly = 16'h0000;
      det_t = 16'h0002;
      go_run();
      hold_fb = hold;
      wait_lvl(6, 1'b1, 80, n);
      wait_lvl(0, 1'b0, 30, n);
      chk_cnt(n, lo, hi, "feedback stop decision");
      hold_fb = 1'b0;
      cyc(60);
   endtask : sc_fb

   task automatic sc_restart;
      int n;
      logic seen;
      stop_mode = STOP_MODE_COAST;
      term_src = 1'b1;
      pot_sel = TERM_ALLOW;
      pl_en = 1'b1;
      run_mem_in = 1'b1;
      rw_t = 16'h0001;
      do_reset();
      wait_lvl(1, 1'b1, 10, n);
      wait_lvl(0, 1'b1, 60, n);
      chk_cnt(n, 39, 50, "restart wait");
      chk_bit(run_mem_out, 1'b1, "restart not remembered");
      stop_req = 1'b1;
      wait_lvl(0, 1'b0, 5, n);
      stop_req = 1'b0;
      pl_en = 1'b0;
      do_reset();
      watch(0, 80, seen);
      chk_bit(seen, 1'b0, "restart while disabled");
   endtask : sc_restart

   task automatic sc_protect;
      int n;
      logic seen;
      run_term = 1'b1;
      pot_sel = TERM_PROTECT;
      do_reset();
      cyc(10);
      chk_bit(protect, 1'b1, "no protection");
      watch(0, 40, seen);
      chk_bit(seen, 1'b0, "ran from held terminal");
      run_term = 1'b0;
      cyc(6);
      chk_bit(protect, 1'b0, "protection kept");
      run_term = 1'b1;
      wait_lvl(0, 1'b1, 20, n);
      pot_sel = TERM_ALLOW;
      do_reset();
      wait_lvl(0, 1'b1, 20, n);
      chk_bit(protect, 1'b0, "protect when allowed");
      run_term = 1'b0;
   endtask : sc_protect

   // -------------------------------------------------------------------
   // main sequence
   // -------------------------------------------------------------------
   initial begin
      rst = 1'b1;
      {run_term, term_src, run_req, stop_req, run_mem_in} = 5'h00;
      {stop_mode, det_src, pl_en, pot_sel, hold_fb} = 5'h00;
      start_ok = 1'b1;
      {brk_f, thr} = {16'h0000, 16'h0032};
      max_f = 16'h1388;
      {demag, dc_t, det_t, spd_dly} = 64'h0;
      {sc_hold, rw_t, st_dly} = 48'h0;
      {dc_cur, sc_cur} = 22'h0;
      do_reset();
      cyc(8);
      sc_start();
      sc_coast();
      sc_brake();
      sc_skip();
      sc_setsrc();
      sc_fb(1'b0, 0, 5);
      sc_fb(1'b1, 8, 16);
      sc_restart();
      sc_protect();
      summarize();
   end
endmodule : testbench

// ---- hdl/dsb_pkg.sv ----
/*
 * dsb_pkg: shared constants and the state type of the drive stop, brake
 * and restart sequencer.
 * Assumes a 100 MHz system clock; all times counted in 10 ms ticks.
 */
package dsb_pkg;

   // -------------------------------------------------------------------
   // widths
   // -------------------------------------------------------------------
   localparam int FREQ_W = 16;   // 0.01 Hz per lsb
   localparam int TIME_W = 16;   // 0.01 s or 0.1 s per lsb
   localparam int PCT_W  = 11;   // 0.1 % per lsb
   localparam int TICK_W = 20;   // timer value in 10 ms ticks

   // -------------------------------------------------------------------
   // timing
   // -------------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS = 10;
   localparam int unsigned TICK_NS       = 10_000_000;
   localparam int unsigned TICK_CYC_DEF  = TICK_NS / CLK_PERIOD_NS;
   // a 0.1 s setting is ten ticks
   localparam logic [TICK_W-1:0] TENTHS_TICKS = 20'h0000A;
   // cycles for the pin synchroniser to fill before the power-on look
   localparam logic [2:0]        INIT_CYC     = 3'h4;

   // -------------------------------------------------------------------
   // encodings and reset values
   // -------------------------------------------------------------------
   localparam logic STOP_MODE_DECEL = 1'b0;
   localparam logic STOP_MODE_COAST = 1'b1;
   localparam logic DET_SET_SPEED   = 1'b0;
   localparam logic DET_FB_SPEED    = 1'b1;
   localparam logic TERM_PROTECT    = 1'b0;
   localparam logic TERM_ALLOW      = 1'b1;
   localparam logic [FREQ_W-1:0] FREQ_RST = 16'h0000;
   localparam logic [TIME_W-1:0] TIME_RST = 16'h0000;
   localparam logic [PCT_W-1:0]  PCT_RST  = 11'h000;

   typedef enum logic [3:0] {
      DSB_INIT, DSB_IDLE, DSB_RESTART_WAIT, DSB_START_DLY, DSB_RUN,
      DSB_DECEL, DSB_DEMAG, DSB_SHORT, DSB_DCB, DSB_SPD_DLY, DSB_DETECT
   } dsb_state_t;

endpackage : dsb_pkg

// ---- hdl/dsb_seq.sv ----
/*
 * dsb_seq: stop braking, stop detection and power-on restart sequencer.
 * Assumes parameters held steady by the operator panel, RUN_TERM from a
 * pin, everything else on SYS_CLK, RUN_MEM_IN valid from reset.
 */
// Operation
// - stop braking only with nonzero brake frequency
// - below brake frequency, block output, wait demag
// - short braking only if hold time nonzero
// - dc braking for its time, then coast
// - dc braking current from its setting
// - short braking current from its setting
// - no brake: stop speed delay then determination
// - set speed source coasts at determination
// - feedback source checks speed, else detect time
// - remembered running state restarts at power-on
// - restart waits programmed time when enabled
// - start delay in standby before output
// - protect against terminal active at power-on
// - allowed terminal starts after initialisation
// - coast mode cuts output at stop
`timescale 1ns/1ps
module dsb_seq
   import dsb_pkg::*;
#(
   parameter int unsigned TICK_CYC = TICK_CYC_DEF
)(
   // clock and reset
   input  wire logic              SYS_CLK,
   input  wire logic              RST,
   // run command
   input  wire logic              RUN_TERM,
   input  wire logic              TERM_SRC,
   input  wire logic              RUN_REQ,
   input  wire logic              STOP_REQ,
   input  wire logic              START_OK,
   input  wire logic              RUN_MEM_IN,
   // settings
   input  wire logic              STOP_MODE_SEL,
   input  wire logic [FREQ_W-1:0] MAX_OUTPUT_FREQ,
   input  wire logic [FREQ_W-1:0] STOP_BRAKE_START_FREQ,
   input  wire logic [TIME_W-1:0] DEMAG_WAIT_TIME,
   input  wire logic [PCT_W-1:0]  STOP_DC_BRAKE_CURRENT,
   input  wire logic [TIME_W-1:0] STOP_DC_BRAKE_TIME,
   input  wire logic [FREQ_W-1:0] STOP_SPEED_THRESHOLD,
   input  wire logic              STOP_DETECT_SOURCE,
   input  wire logic [TIME_W-1:0] STOP_DETECT_TIME,
   input  wire logic [TIME_W-1:0] STOP_SPEED_DELAY,
   input  wire logic [PCT_W-1:0]  SHORT_BRAKE_CURRENT,
   input  wire logic [TIME_W-1:0] SHORT_BRAKE_STOP_HOLD,
   input  wire logic              POWER_LOSS_RESTART_EN,
   input  wire logic [TIME_W-1:0] RESTART_WAIT_TIME,
   input  wire logic [TIME_W-1:0] RUN_START_DELAY,
   input  wire logic              POWERON_TERMINAL_RUN_SEL,
   // motor frequencies
   input  wire logic [FREQ_W-1:0] RAMP_FREQ,
   input  wire logic [FREQ_W-1:0] FB_FREQ,
   // power stage
   output logic                   OUT_EN,
   output logic                   RAMP_DOWN,
   output logic                   SHORT_BRAKE,
   output logic                   DC_BRAKE,
   output logic [PCT_W-1:0]       BRAKE_CUR,
   output logic                   STANDBY,
   // status
   output logic                   RUN_MEM_OUT,
   output logic                   PROTECT
);

   function automatic logic [TICK_W-1:0] tenths(input logic [TIME_W-1:0] v);
      tenths = TICK_W'(v) * TENTHS_TICKS;
   endfunction : tenths

   dsb_state_t        st_ff, nxt_st;
   logic              sync1_ff, sync2_ff;
   logic [2:0]        init_ff;
   logic              prot_ff, auto_ff;
   logic              term_run, run_req, stop_cmd, tmr_load, tmr_done;
   logic [TICK_W-1:0] tmr_val;
   logic [FREQ_W-1:0] lat_bfreq, lat_spd;
   logic [TIME_W-1:0] lat_demag, lat_dct, lat_det, lat_sdly, lat_sh;
   logic [PCT_W-1:0]  lat_dccur, lat_sccur;
   logic              lat_src;
   logic              out_en_ff, ramp_ff, short_ff, dcb_ff, stby_ff, mem_ff;
   logic [PCT_W-1:0]  cur_ff;

   // ------------------------------------------------------------------
   // run command and power-on protection
   // ------------------------------------------------------------------
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         sync1_ff <= 1'b0;
         sync2_ff <= 1'b0;
      end else begin
         sync1_ff <= RUN_TERM;
         sync2_ff <= sync1_ff;
      end
   end

   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         init_ff <= 3'h0;
      end else if (init_ff != INIT_CYC) begin
         init_ff <= init_ff + 3'h1;
      end
   end

   // a level already high after initialisation needs a fresh edge
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         prot_ff <= 1'b0;
      end else if (st_ff == DSB_INIT && init_ff == INIT_CYC) begin
         prot_ff <= (POWERON_TERMINAL_RUN_SEL == TERM_PROTECT)
                    && sync2_ff;
      end else if (!sync2_ff) begin
         prot_ff <= 1'b0;
      end
   end

   // automatic restart holds the run request until an explicit stop
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         auto_ff <= 1'b0;
      end else if (st_ff == DSB_RESTART_WAIT && nxt_st == DSB_START_DLY) begin
         auto_ff <= 1'b1;
      end else if (STOP_REQ) begin
         auto_ff <= 1'b0;
      end
   end

   assign term_run = sync2_ff && !prot_ff;
   assign run_req  = auto_ff || (TERM_SRC ? term_run : RUN_REQ);
   assign stop_cmd = STOP_REQ || !run_req;

   // ------------------------------------------------------------------
   // stop parameters
   // ------------------------------------------------------------------
   // sampled when a decelerating stop begins, held until stopped
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         lat_bfreq <= FREQ_RST;
         lat_spd   <= FREQ_RST;
         lat_demag <= TIME_RST;
         lat_dct   <= TIME_RST;
         lat_det   <= TIME_RST;
         lat_sdly  <= TIME_RST;
         lat_sh    <= TIME_RST;
         lat_dccur <= PCT_RST;
         lat_sccur <= PCT_RST;
         lat_src   <= DET_SET_SPEED;
      end else if (st_ff == DSB_RUN && nxt_st == DSB_DECEL) begin
         lat_bfreq <= (STOP_BRAKE_START_FREQ > MAX_OUTPUT_FREQ) ?
                      MAX_OUTPUT_FREQ : STOP_BRAKE_START_FREQ;
         lat_spd   <= STOP_SPEED_THRESHOLD;
         lat_demag <= DEMAG_WAIT_TIME;
         lat_dct   <= STOP_DC_BRAKE_TIME;
         lat_det   <= STOP_DETECT_TIME;
         lat_sdly  <= STOP_SPEED_DELAY;
         lat_sh    <= SHORT_BRAKE_STOP_HOLD;
         lat_dccur <= STOP_DC_BRAKE_CURRENT;
         lat_sccur <= SHORT_BRAKE_CURRENT;
         lat_src   <= STOP_DETECT_SOURCE;
      end
   end

   // ------------------------------------------------------------------
   // sequencer
   // ------------------------------------------------------------------
   always_comb begin
      nxt_st = st_ff;
      unique case (st_ff)
         DSB_INIT: begin
            if (init_ff == INIT_CYC) begin
               nxt_st = (POWER_LOSS_RESTART_EN && RUN_MEM_IN) ?
                        DSB_RESTART_WAIT : DSB_IDLE;
            end
         end
         DSB_IDLE: begin
            if (run_req && !STOP_REQ) nxt_st = DSB_START_DLY;
         end
         DSB_RESTART_WAIT: begin
            if (STOP_REQ) nxt_st = DSB_IDLE;
            else if (tmr_done && START_OK) nxt_st = DSB_START_DLY;
         end
         DSB_START_DLY: begin
            if (stop_cmd) nxt_st = DSB_IDLE;
            else if (tmr_done) nxt_st = DSB_RUN;
         end
         DSB_RUN: begin
            if (stop_cmd) begin
               nxt_st = (STOP_MODE_SEL == STOP_MODE_COAST) ?
                        DSB_IDLE : DSB_DECEL;
            end
         end
         DSB_DECEL: begin
            if (lat_bfreq != '0) begin
               if (RAMP_FREQ < lat_bfreq) nxt_st = DSB_DEMAG;
            end else if (RAMP_FREQ < lat_spd) begin
               nxt_st = DSB_SPD_DLY;
            end
         end
         DSB_DEMAG: begin
            if (tmr_done) begin
               if (lat_sh != '0) nxt_st = DSB_SHORT;
               else if (lat_dct != '0) nxt_st = DSB_DCB;
               else nxt_st = DSB_IDLE;
            end
         end
         DSB_SHORT: begin
            if (tmr_done) nxt_st = (lat_dct != '0) ? DSB_DCB : DSB_IDLE;
         end
         DSB_DCB: begin
            if (tmr_done) nxt_st = DSB_IDLE;
         end
         DSB_SPD_DLY: begin
            if (tmr_done) begin
               if (lat_src == DET_SET_SPEED) nxt_st = DSB_IDLE;
               else if (FB_FREQ < lat_spd) nxt_st = DSB_IDLE;
               else nxt_st = DSB_DETECT;
            end
         end
         DSB_DETECT: begin
            if (tmr_done) nxt_st = DSB_IDLE;
         end
         default: nxt_st = DSB_IDLE;
      endcase
   end

   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) st_ff <= DSB_INIT;
      else st_ff <= nxt_st;
   end

   // every timed state reloads the single timer on entry
   always_comb begin
      tmr_val = '0;
      unique case (nxt_st)
         DSB_RESTART_WAIT: tmr_val = tenths(RESTART_WAIT_TIME);
         DSB_START_DLY:    tmr_val = tenths(RUN_START_DELAY);
         DSB_DEMAG:        tmr_val = TICK_W'(lat_demag);
         DSB_SHORT:        tmr_val = tenths(lat_sh);
         DSB_DCB:          tmr_val = tenths(lat_dct);
         DSB_SPD_DLY:      tmr_val = tenths(lat_sdly);
         DSB_DETECT:       tmr_val = TICK_W'(lat_det);
         default:          tmr_val = '0;
      endcase
   end

   assign tmr_load = (nxt_st != st_ff);

   dsb_timer #(
      .TICK_CYC (TICK_CYC)
   ) u_timer (
      .SYS_CLK (SYS_CLK),
      .RST     (RST),
      .LOAD    (tmr_load),
      .VALUE   (tmr_val),
      .DONE    (tmr_done)
   );

   // ------------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------------
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         out_en_ff <= 1'b0;
         ramp_ff   <= 1'b0;
         short_ff  <= 1'b0;
         dcb_ff    <= 1'b0;
         stby_ff   <= 1'b0;
         mem_ff    <= 1'b0;
         cur_ff    <= PCT_RST;
      end else begin
         // output stays blocked through demag and both braking phases
         out_en_ff <= nxt_st inside {DSB_RUN, DSB_DECEL, DSB_SPD_DLY,
                                     DSB_DETECT};
         ramp_ff   <= nxt_st inside {DSB_DECEL, DSB_SPD_DLY, DSB_DETECT};
         short_ff  <= (nxt_st == DSB_SHORT);
         dcb_ff    <= (nxt_st == DSB_DCB);
         stby_ff   <= nxt_st inside {DSB_RESTART_WAIT, DSB_START_DLY};
         mem_ff    <= nxt_st inside {DSB_START_DLY, DSB_RUN, DSB_DECEL};
         cur_ff    <= (nxt_st == DSB_SHORT) ? lat_sccur :
                      (nxt_st == DSB_DCB)   ? lat_dccur : PCT_RST;
      end
   end

   assign OUT_EN      = out_en_ff;
   assign RAMP_DOWN   = ramp_ff;
   assign SHORT_BRAKE = short_ff;
   assign DC_BRAKE    = dcb_ff;
   assign BRAKE_CUR   = cur_ff;
   assign STANDBY     = stby_ff;
   assign RUN_MEM_OUT = mem_ff;
   assign PROTECT     = prot_ff;

   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (RST);

   sequence demag_end_s;
      st_ff == DSB_DEMAG && tmr_done;
   endsequence
   sequence det_point_s;
      st_ff == DSB_SPD_DLY && tmr_done;
   endsequence

   brake_gate_a: assert property (
      st_ff == DSB_DECEL && lat_bfreq == '0 |=> st_ff != DSB_DEMAG)
      else $error("braking entered with zero start frequency");
   demag_block_a: assert property (
      st_ff == DSB_DECEL && lat_bfreq != '0 && RAMP_FREQ < lat_bfreq
      |=> st_ff == DSB_DEMAG && !OUT_EN)
      else $error("demag wait not entered with output blocked");
   short_skip_a: assert property (
      demag_end_s and lat_sh == '0 |=> !SHORT_BRAKE)
      else $error("short braking with zero hold time");
   dcb_end_a: assert property (
      st_ff == DSB_DCB && tmr_done |=> st_ff == DSB_IDLE && !DC_BRAKE)
      else $error("dc braking did not end in coast");
   dc_current_a: assert property (
      DC_BRAKE |-> BRAKE_CUR == lat_dccur && !OUT_EN)
      else $error("wrong dc braking current");
   short_current_a: assert property (
      SHORT_BRAKE |-> BRAKE_CUR == lat_sccur && !DC_BRAKE)
      else $error("wrong short braking current");
   spd_delay_a: assert property (
      st_ff == DSB_DECEL && lat_bfreq == '0 && RAMP_FREQ < lat_spd
      |=> st_ff == DSB_SPD_DLY)
      else $error("stop speed delay not started");
   set_source_a: assert property (
      det_point_s and lat_src == DET_SET_SPEED |=> !OUT_EN)
      else $error("set speed source did not coast");
   fb_source_a: assert property (
      det_point_s and lat_src == DET_FB_SPEED
      |=> OUT_EN == ($past(FB_FREQ) >= lat_spd))
      else $error("feedback stop check wrong");
   restart_wait_a: assert property (
      st_ff == DSB_INIT ##1 st_ff == DSB_RESTART_WAIT
      |-> POWER_LOSS_RESTART_EN && !OUT_EN)
      else $error("restart wait without restart enabled");
   start_delay_a: assert property (
      st_ff == DSB_START_DLY |-> !OUT_EN && STANDBY)
      else $error("output during start delay");
   term_prot_a: assert property (
      st_ff == DSB_IDLE && PROTECT && TERM_SRC && !auto_ff
      |=> st_ff == DSB_IDLE)
      else $error("protected terminal accepted");
   coast_stop_a: assert property (
      st_ff == DSB_RUN && stop_cmd && STOP_MODE_SEL == STOP_MODE_COAST
      |=> !OUT_EN && st_ff == DSB_IDLE)
      else $error("coast stop kept output");
   param_hold_a: assert property (
      st_ff inside {DSB_DECEL, DSB_DEMAG, DSB_SHORT, DSB_DCB} |=>
      $stable(lat_dct) && $stable(lat_dccur) && $stable(lat_bfreq))
      else $error("stop parameters changed during stop");

endmodule : dsb_seq

// ---- hdl/dsb_timer.sv ----
/*
 * dsb_timer: down counter in 10 ms ticks with its own prescaler.
 * Assumes load is a one-cycle strobe from the same clock.
 */
`timescale 1ns/1ps
module dsb_timer
   import dsb_pkg::*;
#(
   parameter int unsigned TICK_CYC = TICK_CYC_DEF
)(
   // clock and reset
   input  wire logic              SYS_CLK,
   input  wire logic              RST,
   // control
   input  wire logic              LOAD,
   input  wire logic [TICK_W-1:0] VALUE,
   // status
   output logic                   DONE
);

   logic [31:0]       pre_ff;
   logic [TICK_W-1:0] cnt_ff;
   logic              tick;

   // prescaler restarts on load so the first tick is a full one
   assign tick = (pre_ff == 32'(TICK_CYC - 1));

   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         pre_ff <= 32'h0;
      end else if (LOAD || tick) begin
         pre_ff <= 32'h0;
      end else begin
         pre_ff <= pre_ff + 32'h1;
      end
   end

   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         cnt_ff <= '0;
      end else if (LOAD) begin
         cnt_ff <= VALUE;
      end else if (tick && cnt_ff != '0) begin
         cnt_ff <= cnt_ff - 20'h1;
      end
   end

   // done must not look at load: load follows the state change that done
   // itself decides, and the pair would form a combinational loop
   assign DONE = (cnt_ff == '0);

endmodule : dsb_timer
